/* File: design/brc_bank.sv */
// Register bank of a four-phase step-down regulator, reached over a two-wire serial bus.
// Assumes the open-drain data wire is resolved outside and the mode inputs come from this clock.
//
// Summary of operation
// - Phase limit bits 5:3, 1.5-5.0 A, reset 111.
// - New limit code applies while regulator runs.
// - Codes 00-17 give 0.5 V up, 10 mV.
// - Codes 18-9d give 0.735-1.4 V, 5 mV.
// - Codes 9e-ff give 1.42-3.36 V, 20 mV.
// - Floor code, same encoding, used in floor state.
// - Off delay bits 7:4, 0-15 ms after fall.
// - On delay bits 3:0, 0-15 ms after rise.
// - Soft reset restores defaults, reloads memory, resets bus.
// - Soft reset bit clears itself, reads zero.
// - Config bit 3 picks thermal warning threshold.
// - Config bit 2 connects pin B pull-down.
// - Config bit 1 connects pin A pull-down.
// - Config bit 0 turns spread spectrum on.
// - Roof/floor mode: pin picks normal or floor code.
// - Soft reset sets sticky flag, write one clears.
`timescale 1ns/1ps
`default_nettype none
`include "brc_cfg.svh"
module brc_bank #(
   parameter int MS_CYCLES = `BRC_MS_NS / `BRC_CLK_NS
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   input wire logic enable_pin_a_in,
   input wire logic enable_pin_b_in,
   input wire logic regulator_enable_bit_in,
   input wire logic pin_ctrl_in,
   input wire logic pin_select_in,
   input wire logic roof_floor_pin_mode_in,
   output logic regulator_on_out,
   output logic [7:0] voltage_code_out,
   output logic [11:0] target_mv_out,
   output logic [2:0] phase2_current_limit_out,
   output logic [2:0] phase3_current_limit_out,
   output logic thermal_warning_threshold_sel_out,
   output logic enable_a_pulldown_out,
   output logic enable_b_pulldown_out,
   output logic spread_spectrum_on_out,
   output logic otp_reload_out,
   output logic reset_occurred_out
);
   import brc_pkg::*;

   localparam brc_regs_s REG_RST = '{ph2: `BRC_RST_ILIM, ph3: `BRC_RST_ILIM, vout: `BRC_RST_VOUT,
      floor: `BRC_RST_FLOOR, dly: `BRC_RST_DLY, rst_rsv: `BRC_RST_RSV, cfg: `BRC_RST_CFG};
   // Bus samplers start at the idle high level so the release of reset shows no false edge.
   localparam brc_state_s ST_RST = '{regs: REG_RST, st: BRC_IDLE, oe_n: 1'b1, scl: 3'h7, sda: 3'h7, default: '0};
   localparam logic [`BRC_TICK_W-1:0] TICK_LAST = `BRC_TICK_W'(MS_CYCLES - 1);

   if (MS_CYCLES < 2 || MS_CYCLES >= (1 << `BRC_TICK_W)) begin : g_ms_check
      $error("MS_CYCLES out of range for the tick counter.");
   end

   brc_state_s q;
   brc_state_s n;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic wr;
   logic softrst;
   logic sel;
   logic pinctl;
   logic tick;
   logic [7:0] rd_cur;
   logic [7:0] rd_nxt;

   // ----------------------------------------------------------------
   // Read multiplexer and code-to-voltage map
   // ----------------------------------------------------------------
   function automatic logic [7:0] rmux(input brc_state_s s, input logic [7:0] a);
      case (a)
         `BRC_OFF_PH2: rmux = s.regs.ph2;
         `BRC_OFF_PH3: rmux = s.regs.ph3;
         `BRC_OFF_VOUT: rmux = s.regs.vout;
         `BRC_OFF_FLOOR: rmux = s.regs.floor;
         `BRC_OFF_DLY: rmux = s.regs.dly;
         `BRC_OFF_RST: rmux = {s.regs.rst_rsv, 1'b0};
         `BRC_OFF_CFG: rmux = s.regs.cfg;
         `BRC_OFF_STAT: rmux = {6'h00, s.rst_flag, 1'b0};
         default: rmux = 8'h00;
      endcase
   endfunction

   function automatic logic [11:0] code_mv(input logic [7:0] c);
      if (c <= `BRC_SEG1_END) begin
         code_mv = 12'(`BRC_SEG1_MV + `BRC_SEG1_STEP * int'(c));
      end else if (c <= `BRC_SEG2_END) begin
         code_mv = 12'(`BRC_SEG2_MV + `BRC_SEG2_STEP * int'(c - `BRC_SEG2_START));
      end else begin
         code_mv = 12'(`BRC_SEG3_MV + `BRC_SEG3_STEP * int'(c - `BRC_SEG3_START));
      end
   endfunction

   assign rd_cur = rmux(q, q.ptr);
   assign rd_nxt = rmux(q, q.ptr + 8'h01);
   // Edges are taken only from the second and third stages; the first stage feeds nothing else.
   assign scl_rise = q.scl[1] & ~q.scl[2];
   assign scl_fall = ~q.scl[1] & q.scl[2];
   assign start_c = q.scl[1] & q.scl[2] & ~q.sda[1] & q.sda[2];
   assign stop_c = q.scl[1] & q.scl[2] & q.sda[1] & ~q.sda[2];
   assign sel = pin_select_in ? q.enb[1] : q.ena[1];
   assign pinctl = pin_ctrl_in & ~roof_floor_pin_mode_in;
   assign tick = (q.tick == TICK_LAST);
   assign wr = (q.st == BRC_ACK_W) && scl_fall && !start_c && !stop_c;
   assign softrst = wr && (q.ptr == `BRC_OFF_RST) && q.sr[`BRC_RST_BIT];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n = q;
      n.scl = {q.scl[1:0], scl_in};
      n.sda = {q.sda[1:0], sda_in};
      n.ena = {q.ena[0], enable_pin_a_in};
      n.enb = {q.enb[0], enable_pin_b_in};
      n.otp = 1'b0;
      // Serial slave: sample on the rising clock, change the data wire on the falling one.
      if (start_c) begin
         n.st = BRC_ADDR;
         n.cnt = 4'h0;
         n.oe_n = 1'b1;
      end else if (stop_c) begin
         n.st = BRC_IDLE;
         n.oe_n = 1'b1;
      end else begin
         unique case (q.st)
            BRC_IDLE: begin
            end
            BRC_ADDR, BRC_REG, BRC_WDATA: begin
               if (scl_rise && q.cnt != 4'h8) begin
                  n.sr = {q.sr[6:0], q.sda[1]};
                  n.cnt = q.cnt + 4'h1;
               end else if (scl_fall && q.cnt == 4'h8) begin
                  n.cnt = 4'h0;
                  if (q.st != BRC_ADDR) begin
                     n.oe_n = 1'b0;
                     n.st = (q.st == BRC_REG) ? BRC_ACK_R : BRC_ACK_W;
                  end else if (q.sr[7:1] == `BRC_DEV_ADDR) begin
                     n.oe_n = 1'b0;
                     n.rw = q.sr[0];
                     n.st = BRC_ACK_A;
                  end else begin
                     n.st = BRC_IDLE;
                  end
               end
            end
            BRC_ACK_A: begin
               if (scl_fall) begin
                  if (q.rw) begin
                     n.sr = rd_cur;
                     n.oe_n = rd_cur[7];
                     n.st = BRC_RDATA;
                  end else begin
                     n.oe_n = 1'b1;
                     n.st = BRC_REG;
                  end
               end
            end
            BRC_ACK_R: begin
               if (scl_fall) begin
                  n.oe_n = 1'b1;
                  n.ptr = q.sr;
                  n.st = BRC_WDATA;
               end
            end
            BRC_ACK_W: begin
               if (scl_fall) begin
                  n.oe_n = 1'b1;
                  n.ptr = q.ptr + 8'h01;
                  n.st = BRC_WDATA;
               end
            end
            BRC_RDATA: begin
               if (scl_fall) begin
                  n.cnt = q.cnt + 4'h1;
                  n.sr = {q.sr[6:0], 1'b0};
                  if (q.cnt == 4'h7) begin
                     n.oe_n = 1'b1;
                     n.st = BRC_RACK;
                  end else begin
                     n.oe_n = q.sr[6];
                  end
               end
            end
            BRC_RACK: begin
               if (scl_rise) begin
                  n.acked = ~q.sda[1];
               end else if (scl_fall) begin
                  n.ptr = q.ptr + 8'h01;
                  n.cnt = 4'h0;
                  if (q.acked) begin
                     n.sr = rd_nxt;
                     n.oe_n = rd_nxt[7];
                     n.st = BRC_RDATA;
                  end else begin
                     n.st = BRC_IDLE;
                  end
               end
            end
         endcase
      end
      // Writes commit at the end of the acknowledge so a reset never cuts the acknowledge short.
      if (wr) begin
         case (q.ptr)
            `BRC_OFF_PH2: n.regs.ph2 = q.sr;
            `BRC_OFF_PH3: n.regs.ph3 = q.sr;
            `BRC_OFF_VOUT: n.regs.vout = q.sr;
            `BRC_OFF_FLOOR: n.regs.floor = q.sr;
            `BRC_OFF_DLY: n.regs.dly = q.sr;
            `BRC_OFF_RST: n.regs.rst_rsv = q.sr[7:1];
            `BRC_OFF_CFG: n.regs.cfg = q.sr;
            `BRC_OFF_STAT: n.rst_flag = q.rst_flag & ~q.sr[`BRC_STAT_RST_BIT];
            default: begin
            end
         endcase
      end
      if (softrst) begin
         n.regs = REG_RST;
         n.st = BRC_IDLE;
         n.oe_n = 1'b1;
         n.ptr = 8'h00;
         n.cnt = 4'h0;
         n.otp = 1'b1;
         n.rst_flag = 1'b1;
      end
      // Enable pin timing: any edge reloads the delay and realigns the millisecond tick.
      n.sel_q = sel;
      n.tick = tick ? '0 : q.tick + `BRC_TICK_W'(1);
      if (sel != q.sel_q) begin
         n.pend = 1'b1;
         n.pend_on = sel;
         n.dly_cnt = sel ? q.regs.dly[`BRC_ONDLY_HI:`BRC_ONDLY_LO] : q.regs.dly[`BRC_OFFDLY_HI:`BRC_OFFDLY_LO];
         n.tick = '0;
      end else if (q.pend) begin
         if (q.dly_cnt == 4'h0) begin
            n.pend = 1'b0;
            n.pin_on = q.pend_on;
         end else if (tick) begin
            n.dly_cnt = q.dly_cnt - 4'h1;
         end
      end
      n.reg_on = regulator_enable_bit_in & (~pinctl | q.pin_on);
      n.vcode = (pin_ctrl_in & roof_floor_pin_mode_in & ~sel) ? q.regs.floor : q.regs.vout;
      n.mv = code_mv(q.vcode);
   end

   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         q <= ST_RST;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign sda_out = 1'b0;
   assign sda_oe_n_out = q.oe_n;
   assign regulator_on_out = q.reg_on;
   assign voltage_code_out = q.vcode;
   assign target_mv_out = q.mv;
   assign phase2_current_limit_out = q.regs.ph2[`BRC_ILIM_HI:`BRC_ILIM_LO];
   assign phase3_current_limit_out = q.regs.ph3[`BRC_ILIM_HI:`BRC_ILIM_LO];
   assign thermal_warning_threshold_sel_out = q.regs.cfg[`BRC_CFG_TWARN];
   assign enable_b_pulldown_out = q.regs.cfg[`BRC_CFG_PD_B];
   assign enable_a_pulldown_out = q.regs.cfg[`BRC_CFG_PD_A];
   assign spread_spectrum_on_out = q.regs.cfg[`BRC_CFG_SPREAD];
   assign otp_reload_out = q.otp;
   assign reset_occurred_out = q.rst_flag;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!nrst_in);

   property p_ilim_rst;
      $rose(nrst_in) |-> phase2_current_limit_out == 3'h7 && phase3_current_limit_out == 3'h7;
   endproperty
   a_ilim_rst: assert property (p_ilim_rst) else $error("Limit not at top code after reset.");

   property p_ilim_live;
      (wr && q.ptr == `BRC_OFF_PH2 && !softrst) |=> phase2_current_limit_out == $past(q.sr[5:3]);
   endproperty
   a_ilim_live: assert property (p_ilim_live) else $error("Written limit code not applied.");

   property p_seg1;
      (q.vcode <= 8'h17) |=> target_mv_out == 12'(500 + 10 * int'($past(q.vcode)));
   endproperty
   a_seg1: assert property (p_seg1) else $error("Low segment voltage wrong.");

   property p_seg2;
      (q.vcode >= 8'h18 && q.vcode <= 8'h9d) |=> target_mv_out == 12'(735 + 5 * (int'($past(q.vcode)) - 24));
   endproperty
   a_seg2: assert property (p_seg2) else $error("Middle segment voltage wrong.");

   property p_seg3;
      (q.vcode >= 8'h9e) |=> target_mv_out == 12'(1420 + 20 * (int'($past(q.vcode)) - 158));
   endproperty
   a_seg3: assert property (p_seg3) else $error("High segment voltage wrong.");

   property p_floor;
      (pin_ctrl_in && roof_floor_pin_mode_in && !sel) |=> voltage_code_out == $past(q.regs.floor);
   endproperty
   a_floor: assert property (p_floor) else $error("Floor code not selected.");

   property p_roof;
      (pin_ctrl_in && roof_floor_pin_mode_in && sel) |=> voltage_code_out == $past(q.regs.vout);
   endproperty
   a_roof: assert property (p_roof) else $error("Normal code not selected in roof state.");

   property p_cfg_rst;
      $rose(nrst_in) |-> !thermal_warning_threshold_sel_out && enable_b_pulldown_out && enable_a_pulldown_out
         && !spread_spectrum_on_out;
   endproperty
   a_cfg_rst: assert property (p_cfg_rst) else $error("Configuration bits not at defaults after reset.");

   property p_on_zero;
      (sel && !q.sel_q && q.regs.dly[3:0] == 4'h0 && pinctl && regulator_enable_bit_in && !softrst)
         ##1 (sel && pinctl && regulator_enable_bit_in)[*2] |=> regulator_on_out;
   endproperty
   a_on_zero: assert property (p_on_zero) else $error("Zero start-up delay not immediate.");

   property p_soft;
      softrst |=> q.regs.vout == `BRC_RST_VOUT && q.st == BRC_IDLE && otp_reload_out && sda_oe_n_out;
   endproperty
   a_soft: assert property (p_soft) else $error("Soft reset did not restore defaults.");

   property p_flag;
      softrst |=> reset_occurred_out ##1 $stable(reset_occurred_out) || $past(wr);
   endproperty
   a_flag: assert property (p_flag) else $error("Reset flag not set or lost.");

   property p_flag_clr;
      (wr && q.ptr == `BRC_OFF_STAT && q.sr[`BRC_STAT_RST_BIT]) |=> !reset_occurred_out;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("Reset flag not cleared by write.");
endmodule
`default_nettype wire

/* File: design/brc_cfg.svh */
// Offsets, field positions, reset values and timing figures of the regulator control bank.
// Assumes inclusion by bare name from the package and the bank.
`ifndef BRC_CFG_SVH
`define BRC_CFG_SVH
`define BRC_OFF_PH2 8'h07
`define BRC_OFF_PH3 8'h09
`define BRC_OFF_VOUT 8'h0a
`define BRC_OFF_FLOOR 8'h0b
`define BRC_OFF_DLY 8'h12
`define BRC_OFF_RST 8'h16
`define BRC_OFF_CFG 8'h17
`define BRC_OFF_STAT 8'h18
`define BRC_ILIM_HI 5
`define BRC_ILIM_LO 3
`define BRC_OFFDLY_HI 7
`define BRC_OFFDLY_LO 4
`define BRC_ONDLY_HI 3
`define BRC_ONDLY_LO 0
`define BRC_RST_BIT 0
`define BRC_STAT_RST_BIT 1
`define BRC_CFG_TWARN 3
`define BRC_CFG_PD_B 2
`define BRC_CFG_PD_A 1
`define BRC_CFG_SPREAD 0
`define BRC_RST_ILIM 8'h3a
`define BRC_RST_VOUT 8'h61
`define BRC_RST_FLOOR 8'h00
`define BRC_RST_DLY 8'h00
`define BRC_RST_RSV 7'h00
`define BRC_RST_CFG 8'h06
`define BRC_DEV_ADDR 7'h60
`define BRC_MS_NS 1000000
`define BRC_CLK_NS 8
`define BRC_TICK_W 17
`define BRC_SEG1_END 8'h17
`define BRC_SEG2_END 8'h9d
`define BRC_SEG2_START 8'h18
`define BRC_SEG3_START 8'h9e
`define BRC_SEG1_MV 500
`define BRC_SEG2_MV 735
`define BRC_SEG3_MV 1420
`define BRC_SEG1_STEP 10
`define BRC_SEG2_STEP 5
`define BRC_SEG3_STEP 20
`endif

/* File: design/brc_pkg.sv */
// Types shared by the regulator control bank.
// Assumes the configuration header sits beside this file.
`include "brc_cfg.svh"
package brc_pkg;
   typedef enum logic [3:0] {BRC_IDLE, BRC_ADDR, BRC_ACK_A, BRC_REG, BRC_ACK_R, BRC_WDATA, BRC_ACK_W,
      BRC_RDATA, BRC_RACK} brc_bus_e;
   typedef struct packed {
      logic [7:0] ph2;
      logic [7:0] ph3;
      logic [7:0] vout;
      logic [7:0] floor;
      logic [7:0] dly;
      logic [6:0] rst_rsv;
      logic [7:0] cfg;
   } brc_regs_s;
   typedef struct packed {
      brc_regs_s regs;
      brc_bus_e st;
      logic [7:0] sr;
      logic [3:0] cnt;
      logic [7:0] ptr;
      logic rw;
      logic acked;
      logic oe_n;
      logic [2:0] scl;
      logic [2:0] sda;
      logic [1:0] ena;
      logic [1:0] enb;
      logic sel_q;
      logic [`BRC_TICK_W-1:0] tick;
      logic [3:0] dly_cnt;
      logic pend;
      logic pend_on;
      logic pin_on;
      logic reg_on;
      logic [7:0] vcode;
      logic [11:0] mv;
      logic rst_flag;
      logic otp;
   } brc_state_s;
endpackage

/* File: tb/brc_host_model.sv */
// Bus host model that reaches the regulator control bank over the two-wire serial bus.
// Assumes the bench resolves the pulled-up data wire and feeds it back on sda_in.
`timescale 1ns/1ps
`default_nettype none
`include "brc_cfg.svh"
module brc_host_model #(
   parameter int HALF = 8
) (
   input wire logic mclk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_rel_out,
   output logic done_out,
   output logic [7:0] data_out
);
   int nacks = 0;
   initial begin
      scl_out = 1'b1;
      sda_rel_out = 1'b1;
      done_out = 1'b0;
      data_out = 8'h00;
   end
   task automatic hold();
      repeat (HALF) @(negedge mclk_in);
   endtask
   // Data moves two cycles after the clock falls, so the device never sees both wires change at once.
   task automatic bit_io(input logic b, output logic r);
      sda_rel_out = b;
      hold();
      scl_out = 1'b1;
      hold();
      r = sda_in;
      scl_out = 1'b0;
      repeat (2) @(negedge mclk_in);
   endtask
   task automatic start();
      sda_rel_out = 1'b1;
      hold();
      scl_out = 1'b1;
      hold();
      sda_rel_out = 1'b0;
      hold();
      scl_out = 1'b0;
      hold();
   endtask
   task automatic stop();
      sda_rel_out = 1'b0;
      hold();
      scl_out = 1'b1;
      hold();
      sda_rel_out = 1'b1;
      hold();
   endtask
   task automatic tx(input logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, r);
      if (r !== 1'b0) nacks++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start();
      tx({`BRC_DEV_ADDR, 1'b0});
      tx(a);
      tx(d);
      stop();
   endtask
   task automatic rd(input logic [7:0] a);
      logic [7:0] v;
      logic r;
      start();
      tx({`BRC_DEV_ADDR, 1'b0});
      tx(a);
      start();
      tx({`BRC_DEV_ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(1'b1, r);
      stop();
      data_out = v;
      done_out = 1'b1;
      @(negedge mclk_in);
      done_out = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/test_buck_regulator_control_regs.sv */
// Self-checking bench for the regulator control bank, driven through the bus host model.
// Assumes the bank package compiles first; the millisecond count is shortened to MS cycles.
`timescale 1ns/1ps
`default_nettype none
module test_buck_regulator_control_regs;
   import brc_pkg::*;
   localparam int MS = 20;
   logic mclk = 1'b0, nrst = 1'b0, en_bit = 1'b1, pin_ctrl = 1'b1, pin_sel = 1'b0, rf_mode = 1'b0;
   logic pin_a = 1'b0, pin_b = 1'b0;
   logic scl, rel, done, sda_o, oe_n, reg_on, otp, rst_seen, thr, pdb, pda, ss;
   logic [7:0] rdata, vcode;
   logic [11:0] mv;
   logic [2:0] lim2, lim3;
   logic [15:0] seed = 16'h45fa;
   logic [7:0] exp_q[$];
   logic [7:0] offs[9] = '{8'h07, 8'h09, 8'h0a, 8'h0b, 8'h12, 8'h16, 8'h17, 8'h18, 8'h30};
   logic [7:0] defs[9] = '{8'h3a, 8'h3a, 8'h61, 8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00};
   logic [7:0] codes[7] = '{8'h00, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff, 8'h00};
   logic [7:0] cfgs[4] = '{8'h08, 8'h04, 8'h02, 8'h01};
   int err_total = 0, samples_checked = 0, otp_n = 0;
   wire logic sda_w = rel & (oe_n | sda_o);
   always #4 mclk = ~mclk;
   brc_bank #(.MS_CYCLES(MS)) dut (.mclk_in(mclk), .nrst_in(nrst), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_o), .sda_oe_n_out(oe_n), .enable_pin_a_in(pin_a), .enable_pin_b_in(pin_b),
      .regulator_enable_bit_in(en_bit), .pin_ctrl_in(pin_ctrl), .pin_select_in(pin_sel),
      .roof_floor_pin_mode_in(rf_mode), .regulator_on_out(reg_on), .voltage_code_out(vcode),
      .target_mv_out(mv), .phase2_current_limit_out(lim2), .phase3_current_limit_out(lim3),
      .thermal_warning_threshold_sel_out(thr), .enable_a_pulldown_out(pda), .enable_b_pulldown_out(pdb),
      .spread_spectrum_on_out(ss), .otp_reload_out(otp), .reset_occurred_out(rst_seen));
   brc_host_model host (.mclk_in(mclk), .sda_in(sda_w), .scl_out(scl), .sda_rel_out(rel),
      .done_out(done), .data_out(rdata));
   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [11:0] mv_of(input logic [7:0] c);
      if (c <= 8'h17) return 12'(500 + 10 * c);
      if (c <= 8'h9d) return 12'(735 + 5 * (c - 8'h18));
      return 12'(1420 + 20 * (c - 8'h9e));
   endfunction
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask
   task automatic settle();
      repeat (8) @(negedge mclk);
   endtask
   // Checks just before and just after the expected switching moment of the delayed regulator.
   task automatic pin_step(input logic lvl, input int ms);
      pin_a = lvl;
      repeat (ms * MS + 2) @(negedge mclk);
      chk(reg_on, !lvl);
      repeat (6) @(negedge mclk);
      chk(reg_on, lvl);
   endtask
   always @(posedge done) chk({4'h0, rdata}, exp_q.pop_front());
   always @(negedge mclk) if (otp === 1'b1) otp_n++;
   initial begin
      repeat (90000) @(posedge mclk);
      err_total++;
      complete_run();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(negedge mclk);
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      foreach (offs[i]) rd_exp(offs[i], defs[i]);
      chk({lim2, lim3, thr, pdb, pda, ss}, {6'h3f, 4'h6});
      pin_step(1'b1, 0);
      pin_step(1'b0, 0);
      host.wr(8'h12, 8'h21);
      pin_step(1'b1, 1);
      pin_step(1'b0, 2);
      pin_a = 1'b1;
      repeat (10) @(negedge mclk);
      pin_a = 1'b0;
      repeat (3) @(negedge mclk);
      pin_step(1'b1, 1);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         host.wr(8'h07, {2'b00, 3'(i), 3'b010});
         host.wr(8'h09, {2'b00, seed[2:0], 3'b010});
         settle();
         chk({lim2, lim3}, {3'(i), seed[2:0]});
         chk(reg_on, 1'b1);
      end
      rd_exp(8'h09, {2'b00, seed[2:0], 3'b010});
      pin_ctrl = 1'b0;
      seed = lfsr(seed);
      codes[6] = seed[7:0];
      foreach (codes[i]) begin
         host.wr(8'h0a, codes[i]);
         settle();
         chk(vcode, codes[i]);
         chk(mv, mv_of(codes[i]));
      end
      host.wr(8'h0b, 8'h9e);
      pin_ctrl = 1'b1;
      rf_mode = 1'b1;
      pin_sel = 1'b1;
      settle();
      chk(mv, mv_of(8'h9e));
      pin_b = 1'b1;
      settle();
      chk(vcode, codes[6]);
      foreach (cfgs[i]) begin
         host.wr(8'h17, cfgs[i]);
         settle();
         chk({thr, pdb, pda, ss}, cfgs[i][3:0]);
      end
      host.wr(8'h16, 8'h01);
      settle();
      chk(rst_seen, 1'b1);
      chk({lim2, pdb, pda}, {3'h7, 2'b11});
      chk(12'(otp_n), 12'h1);
      rd_exp(8'h0a, 8'h61);
      rd_exp(8'h16, 8'h00);
      rd_exp(8'h18, 8'h02);
      host.wr(8'h18, 8'h02);
      settle();
      chk(rst_seen, 1'b0);
      chk(12'(host.nacks), 12'h0);
      chk(12'(exp_q.size()), 12'h0);
      complete_run();
   end
endmodule
`default_nettype wire
